// File: gio_pad_model.sv
// far side of the port: pads, outside drivers and pull resistors
module gio_pad_model (
   input  wire logic       aclk,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pin_pull_up,
   input  wire logic [7:0] pin_pull_down,
   input  wire logic [7:0] ext_drive,
   input  wire logic [7:0] ext_en,
   output logic [7:0]      pin_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // undriven pads wander every cycle, so a floating pin never looks stable
   logic [7:0] float_r = 8'h55;

   // pattern for pads that nobody drives or pulls
   always @(posedge aclk) begin
      float_r <= ~float_r;
   end

   // device drive wins, then outside driver, then pulls
   assign pin_level = (pin_oe & pin_out)
                    | (~pin_oe & ext_en & ext_drive)
                    | (~pin_oe & ~ext_en & (pin_pull_up | (~pin_pull_down & float_r)));
endmodule : gio_pad_model

// File: gio_pkg.sv
package gio_pkg;
   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_DATA  = 16'hf220;
   localparam logic [15:0] IDX_DIR   = 16'hf221;
   localparam logic [15:0] IDX_CFGLO = 16'hf222;
   localparam logic [15:0] IDX_CFGHI = 16'hf223;
   localparam logic [15:0] IDX_FSLO  = 16'hf224;
   localparam logic [15:0] IDX_FSHI  = 16'hf225;
   localparam int          ADDR_W    = 18;
   localparam int          IDX_LSB   = 2;
   localparam int          NPIN      = 8;
   localparam logic [7:0]  REG_RST   = 8'h00;
   // drive and pull codes, {hi bit, lo bit}
   localparam logic [1:0]  CFG_HIZ   = 2'h0;
   localparam logic [1:0]  CFG_PCH   = 2'h1;
   localparam logic [1:0]  CFG_NCH   = 2'h2;
   localparam logic [1:0]  CFG_CMOS  = 2'h3;
   localparam logic [1:0]  IN_PDN    = 2'h1;
   localparam logic [1:0]  IN_PUP    = 2'h2;
   // function select codes
   localparam logic [1:0]  FS_GPIO   = 2'h0;
   localparam logic [1:0]  FS_SEC    = 2'h1;
   localparam logic [1:0]  FS_TER    = 2'h2;
   localparam logic [1:0]  FS_FRT    = 2'h3;
   // pins that have each alternate function
   localparam logic [7:0]  SEC_OK    = 8'h0f;
   localparam logic [7:0]  TER_OK    = 8'hff;
   localparam logic [7:0]  FRT_OK    = 8'h08;
   localparam logic [1:0]  RESP_OK   = 2'h0;
   localparam logic [1:0]  RESP_ERR  = 2'h2;
endpackage : gio_pkg

// File: gio_port.sv
// How it works
// - output pins driven from data register
// - written data read back on output pins
// - input pins read live pin level
// - bit zero is low, one high
// - direction zero output, one input; reset output
// - bit n maps to pin n
// - data and direction at their indices
// - config, select pairs; low accepts halfword
// - every register clears on reset
// - pin0 i2c data, serial data in
// - pin1 i2c clock, serial clock
// - two bits pick drive or pull
//
// Added by the designer: the AXI4-Lite slave port.
module gio_port
(
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [gio_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   input  wire logic [gio_pkg::ADDR_W-1:0] araddr,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [31:0]                 rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   input  wire logic [7:0]             pin_in,
   output logic [7:0]                  pin_out,
   output logic [7:0]                  pin_oe,
   output logic [7:0]                  pin_pull_up,
   output logic [7:0]                  pin_pull_down,
   input  wire logic                   i2c_sda_out,
   input  wire logic                   i2c_sda_oe,
   input  wire logic                   i2c_scl_out,
   input  wire logic                   i2c_scl_oe,
   output logic                        i2c_sda_in,
   output logic                        i2c_scl_in,
   input  wire logic                   sync_serial_data_out,
   input  wire logic                   sync_serial_clock_out,
   input  wire logic                   sync_serial_clock_oe,
   output logic                        sync_serial_data_in,
   output logic                        sync_serial_clock_in,
   input  wire logic                   uart_a_transmit,
   input  wire logic                   uart_b_transmit,
   output logic                        uart_a_receive,
   input  wire logic                   pwm_channel_a,
   input  wire logic                   pwm_channel_b
);
   import gio_pkg::*;

   // software registers
   logic [7:0]  port_data_r;         // stored output levels
   logic [7:0]  port_direction_r;    // 1 = input
   logic [7:0]  cfg_lo_r;            // drive code low bits
   logic [7:0]  cfg_hi_r;            // drive code high bits
   logic [7:0]  fs_lo_r;             // select code low bits
   logic [7:0]  fs_hi_r;             // select code high bits
   // pin synchroniser
   logic [7:0]  pin_s1_r;            // first stage, read by second only
   logic [7:0]  pin_s2_r;            // safe sampled level
   // bus slave state
   logic [ADDR_W-1:0] aw_addr_r;     // held write address
   logic        aw_full_r;           // write address held
   logic        aw_full_nxt;
   logic [31:0] w_data_r;            // held write data
   logic [3:0]  w_strb_r;            // held strobes
   logic        w_full_r;            // write data held
   logic        w_full_nxt;
   logic        awready_r;
   logic        wready_r;
   logic        bvalid_r;
   logic        bvalid_nxt;
   logic [1:0]  bresp_r;
   logic        arready_r;
   logic        rvalid_r;
   logic        rvalid_nxt;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   // registered pin and peripheral outputs
   logic [7:0]  pin_out_r;
   logic [7:0]  pin_oe_r;
   logic [7:0]  pull_up_r;
   logic [7:0]  pull_dn_r;
   logic        sda_in_r;
   logic        scl_in_r;
   logic        ss_din_r;
   logic        ss_cin_r;
   logic        rxd_r;

   // handshake decode
   wire         aw_take = awvalid & awready_r;
   wire         w_take  = wvalid & wready_r;
   wire         wr_fire = aw_full_r & w_full_r & ~bvalid_r;
   wire         ar_take = arvalid & arready_r;
   wire [15:0]  wr_idx  = aw_addr_r[ADDR_W-1:IDX_LSB];
   wire [15:0]  rd_idx  = araddr[ADDR_W-1:IDX_LSB];

   // write address decode
   wire wr_data  = wr_fire & (wr_idx == IDX_DATA);
   wire wr_dir   = wr_fire & (wr_idx == IDX_DIR);
   wire wr_cfglo = wr_fire & (wr_idx == IDX_CFGLO);
   wire wr_cfghi = wr_fire & (wr_idx == IDX_CFGHI);
   wire wr_fslo  = wr_fire & (wr_idx == IDX_FSLO);
   wire wr_fshi  = wr_fire & (wr_idx == IDX_FSHI);
   wire wr_hit   = wr_data | wr_dir | wr_cfglo | wr_cfghi | wr_fslo | wr_fshi;
   // byte lanes; lane 1 of a low register reaches its partner
   wire ln0      = w_strb_r[0];
   wire ln1      = w_strb_r[1];

   // next register values
   wire [7:0] data_nxt  = (wr_data & ln0) ? w_data_r[7:0] : port_data_r;
   wire [7:0] dir_nxt   = (wr_dir & ln0) ? w_data_r[7:0] : port_direction_r;
   wire [7:0] cfglo_nxt = (wr_cfglo & ln0) ? w_data_r[7:0] : cfg_lo_r;
   wire [7:0] cfghi_nxt = (wr_cfghi & ln0) ? w_data_r[7:0] :
                          (wr_cfglo & ln1) ? w_data_r[15:8] : cfg_hi_r;
   wire [7:0] fslo_nxt  = (wr_fslo & ln0) ? w_data_r[7:0] : fs_lo_r;
   wire [7:0] fshi_nxt  = (wr_fshi & ln0) ? w_data_r[7:0] :
                          (wr_fslo & ln1) ? w_data_r[15:8] : fs_hi_r;

   // readback: input pins show live level, output pins stored bit
   wire [7:0] data_view = (port_direction_r & pin_s2_r)
                        | (~port_direction_r & port_data_r);

   // read decode; unmapped reads return zero and an error
   wire rd_hit = (rd_idx >= IDX_DATA) & (rd_idx <= IDX_FSHI);
   logic [31:0] rd_val;
   always_comb begin
      case (rd_idx)
         IDX_DATA:  rd_val = {24'h00_0000, data_view};
         IDX_DIR:   rd_val = {24'h00_0000, port_direction_r};
         IDX_CFGLO: rd_val = {16'h0000, cfg_hi_r, cfg_lo_r};
         IDX_CFGHI: rd_val = {24'h00_0000, cfg_hi_r};
         IDX_FSLO:  rd_val = {16'h0000, fs_hi_r, fs_lo_r};
         IDX_FSHI:  rd_val = {24'h00_0000, fs_hi_r};
         default:   rd_val = 32'h0000_0000;
      endcase
   end

   // channel holding state; aw and w are taken in either order
   assign aw_full_nxt = aw_full_r ? ~wr_fire : aw_take;
   assign w_full_nxt  = w_full_r ? ~wr_fire : w_take;
   assign bvalid_nxt  = wr_fire | (bvalid_r & ~bready);
   assign rvalid_nxt  = ar_take | (rvalid_r & ~rready);

   // alternate outputs per pin, in pin order 7..0
   wire [7:0] sec_val = {4'h0, uart_a_transmit, 1'b0, i2c_scl_out, i2c_sda_out};
   wire [7:0] sec_oe  = {4'h0, 1'b1, 1'b0, i2c_scl_oe, i2c_sda_oe};
   wire [7:0] ter_val = {pwm_channel_b, sync_serial_data_out, sync_serial_clock_out,
                         1'b0, pwm_channel_a, sync_serial_data_out,
                         sync_serial_clock_out, 1'b0};
   wire [7:0] ter_oe  = {1'b1, 1'b1, sync_serial_clock_oe, 1'b0,
                         1'b1, 1'b1, sync_serial_clock_oe, 1'b0};
   wire [7:0] frt_val = {4'h0, uart_b_transmit, 3'h0};
   wire [7:0] frt_oe  = FRT_OK;

   // per-pin drive and pull decode
   logic [7:0] out_nxt;
   logic [7:0] oe_nxt;
   logic [7:0] pu_nxt;
   logic [7:0] pd_nxt;
   logic [7:0] sel_sec;
   logic [7:0] sel_ter;
   genvar g;
   generate
      for (g = 0; g < NPIN; g++) begin : g_pin
         wire [1:0] fs  = {fs_hi_r[g], fs_lo_r[g]};
         wire [1:0] cfg = {cfg_hi_r[g], cfg_lo_r[g]};
         // prohibited codes fall back to a fixed low level
         wire       ok  = (fs == FS_GPIO) | ((fs == FS_SEC) & SEC_OK[g])
                        | ((fs == FS_TER) & TER_OK[g]) | ((fs == FS_FRT) & FRT_OK[g]);
         wire       dv  = ~ok ? 1'b0 :
                          (fs == FS_SEC) ? sec_val[g] :
                          (fs == FS_TER) ? ter_val[g] :
                          (fs == FS_FRT) ? frt_val[g] : port_data_r[g];
         // a bidirectional peripheral may release the pin
         wire       de  = ~ok ? 1'b1 :
                          (fs == FS_SEC) ? sec_oe[g] :
                          (fs == FS_TER) ? ter_oe[g] :
                          (fs == FS_FRT) ? frt_oe[g] : 1'b1;
         wire       drv = ~port_direction_r[g] & de;
         assign out_nxt[g] = (cfg == CFG_PCH) | ((cfg == CFG_CMOS) & dv);
         assign oe_nxt[g]  = drv & (((cfg == CFG_PCH) & dv)
                                  | ((cfg == CFG_NCH) & ~dv)
                                  | (cfg == CFG_CMOS));
         assign pu_nxt[g]  = port_direction_r[g] & (cfg == IN_PUP);
         assign pd_nxt[g]  = port_direction_r[g] & (cfg == IN_PDN);
         assign sel_sec[g] = fs == FS_SEC;
         assign sel_ter[g] = fs == FS_TER;
      end
   endgenerate

   // inputs handed to peripherals; idle high when not routed
   wire sda_nxt = sel_sec[0] ? pin_s2_r[0] : 1'b1;
   wire scl_nxt = sel_sec[1] ? pin_s2_r[1] : 1'b1;
   wire rxd_nxt = sel_sec[2] ? pin_s2_r[2] : 1'b1;
   wire ssd_nxt = sel_ter[0] ? pin_s2_r[0] :
                  sel_ter[4] ? pin_s2_r[4] : 1'b1;
   wire ssc_nxt = sel_ter[1] ? pin_s2_r[1] :
                  sel_ter[5] ? pin_s2_r[5] : 1'b1;

   // pin synchroniser, two stages
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {pin_s1_r, pin_s2_r} <= {2{REG_RST}};
      end else begin
         pin_s1_r <= pin_in;
         pin_s2_r <= pin_s1_r;
      end
   end

   // software registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {port_data_r, port_direction_r, cfg_lo_r, cfg_hi_r, fs_lo_r, fs_hi_r} <= {6{REG_RST}};
      end else begin
         port_data_r      <= data_nxt;
         port_direction_r <= dir_nxt;
         cfg_lo_r         <= cfglo_nxt;
         cfg_hi_r         <= cfghi_nxt;
         fs_lo_r          <= fslo_nxt;
         fs_hi_r          <= fshi_nxt;
      end
   end

   // write channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {aw_full_r, w_full_r, awready_r, wready_r, bvalid_r} <= 5'h00;
         bresp_r   <= RESP_OK;
         aw_addr_r <= '0;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
      end else begin
         aw_full_r <= aw_full_nxt;
         w_full_r  <= w_full_nxt;
         awready_r <= ~aw_full_nxt;
         wready_r  <= ~w_full_nxt;
         bvalid_r  <= bvalid_nxt;
         if (wr_fire) begin
            bresp_r <= wr_hit ? RESP_OK : RESP_ERR;
         end
         if (aw_take) begin
            aw_addr_r <= awaddr;
         end
         if (w_take) begin
            w_data_r <= wdata;
            w_strb_r <= wstrb;
         end
      end
   end

   // read channel; data captured when the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {arready_r, rvalid_r} <= 2'h0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= RESP_OK;
      end else begin
         arready_r <= ~rvalid_nxt;
         rvalid_r  <= rvalid_nxt;
         if (ar_take) begin
            rdata_r <= rd_val;
            rresp_r <= rd_hit ? RESP_OK : RESP_ERR;
         end
      end
   end

   // pin and peripheral outputs, registered to avoid glitches
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {pin_out_r, pin_oe_r, pull_up_r, pull_dn_r} <= {4{REG_RST}};
         // peripheral inputs idle high so no false edge follows reset
         {sda_in_r, scl_in_r, ss_din_r, ss_cin_r, rxd_r} <= 5'h1f;
      end else begin
         {pin_out_r, pin_oe_r, pull_up_r, pull_dn_r} <= {out_nxt, oe_nxt, pu_nxt, pd_nxt};
         {sda_in_r, scl_in_r, ss_din_r, ss_cin_r, rxd_r} <=
            {sda_nxt, scl_nxt, ssd_nxt, ssc_nxt, rxd_nxt};
      end
   end

   // port drivers
   assign awready              = awready_r;
   assign wready               = wready_r;
   assign bvalid               = bvalid_r;
   assign bresp                = bresp_r;
   assign arready              = arready_r;
   assign rvalid               = rvalid_r;
   assign rdata                = rdata_r;
   assign rresp                = rresp_r;
   assign pin_out              = pin_out_r;
   assign pin_oe               = pin_oe_r;
   assign pin_pull_up          = pull_up_r;
   assign pin_pull_down        = pull_dn_r;
   assign i2c_sda_in           = sda_in_r;
   assign i2c_scl_in           = scl_in_r;
   assign sync_serial_data_in  = ss_din_r;
   assign sync_serial_clock_in = ss_cin_r;
   assign uart_a_receive       = rxd_r;

   // helper masks for the checks
   wire [7:0] gp_mask = ~(fs_hi_r | fs_lo_r) & ~port_direction_r;
   wire [7:0] cm_mask = gp_mask & cfg_hi_r & cfg_lo_r;
   wire [7:0] nc_mask = gp_mask & cfg_hi_r & ~cfg_lo_r;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   cmos_drive_a: assert property (
      (((pin_out_r ^ $past(port_data_r)) | ~pin_oe_r) & $past(cm_mask)) == 8'h00)
      else $error("cmos pin not driven from data");
   nch_drive_a: assert property (
      ((pin_out_r | (pin_oe_r ^ ~$past(port_data_r))) & $past(nc_mask)) == 8'h00)
      else $error("open drain low drive wrong");
   input_float_a: assert property (
      (pin_oe_r & $past(port_direction_r)) == 8'h00)
      else $error("input pin is driven");
   rd_out_a: assert property (
      ar_take && rd_idx == IDX_DATA |=> rvalid_r
         && ((rdata_r[7:0] ^ $past(port_data_r)) & ~$past(port_direction_r)) == 8'h00)
      else $error("output bit readback wrong");
   rd_in_a: assert property (
      ar_take && rd_idx == IDX_DATA |=> rvalid_r
         && ((rdata_r[7:0] ^ $past(pin_s2_r)) & $past(port_direction_r)) == 8'h00)
      else $error("input bit readback wrong");
   dir_write_a: assert property (
      wr_fire && wr_idx == IDX_DIR && ln0 |=> port_direction_r == $past(w_data_r[7:0]))
      else $error("direction write lost");
   word_write_a: assert property (
      wr_fire && wr_idx == IDX_FSLO && ln1 && ln0
         |=> fs_hi_r == $past(w_data_r[15:8]) && fs_lo_r == $past(w_data_r[7:0]))
      else $error("halfword select write wrong");
   pull_up_a: assert property (
      port_direction_r[5] && cfg_hi_r[5] && !cfg_lo_r[5] |=> pull_up_r[5] && !pull_dn_r[5])
      else $error("pull up missing");
   sda_route_a: assert property (
      sel_sec[0] |=> i2c_sda_in == $past(pin_s2_r[0]))
      else $error("sda input not routed");
   scl_route_a: assert property (
      sel_sec[1] && !port_direction_r[1] && cfg_lo_r[1] && cfg_hi_r[1]
         |=> pin_out_r[1] == $past(i2c_scl_out) && pin_oe_r[1] == $past(i2c_scl_oe))
      else $error("scl output not routed");
   pwm_route_a: assert property (
      sel_ter[3] && !port_direction_r[3] && cfg_lo_r[3] && cfg_hi_r[3]
         |=> pin_oe_r[3] && pin_out_r[3] == $past(pwm_channel_a))
      else $error("pwm not routed");
   wr_resp_a: assert property (
      wr_fire |=> bvalid_r ##0 bresp_r == ($past(wr_hit) ? RESP_OK : RESP_ERR))
      else $error("write answer wrong");
   reset_clear_a: assert property (@(posedge aclk)
      $past(!aresetn) |-> port_data_r == REG_RST && port_direction_r == REG_RST
         && cfg_lo_r == REG_RST && fs_hi_r == REG_RST)
      else $error("register not cleared");

   cov_write: cover property (wr_fire && wr_hit);
   cov_read_in: cover property (ar_take && rd_idx == IDX_DATA && port_direction_r != 8'h00);
   cov_word: cover property (wr_fire && wr_idx == IDX_CFGLO && ln1);
   cov_alt: cover property (sel_ter[7] && pin_oe_r[7]);

endmodule : gio_port

// File: tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import gio_pkg::*;
   logic aclk = 0, aresetn = 0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata = '0, rdata;
   logic [3:0]  wstrb = '0;
   logic [1:0]  bresp, rresp;
   logic [7:0]  pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down;
   logic [7:0]  ext_drive = '0, ext_en = '0;
   logic i2c_sda_out = 0, i2c_sda_oe = 0, i2c_scl_out = 0, i2c_scl_oe = 0;
   logic sync_serial_data_out = 0, sync_serial_clock_out = 0, sync_serial_clock_oe = 0;
   logic uart_a_transmit = 1, uart_b_transmit = 1, pwm_channel_a = 0, pwm_channel_b = 0;
   logic i2c_sda_in, i2c_scl_in, sync_serial_data_in, sync_serial_clock_in, uart_a_receive;
   int n_errors = 0, check_count = 0, cyc = 0;
   logic [31:0] rd_v;
   logic [1:0]  rsp;

   gio_port uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .pin_in, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down,
      .i2c_sda_out, .i2c_sda_oe, .i2c_scl_out, .i2c_scl_oe, .i2c_sda_in, .i2c_scl_in,
      .sync_serial_data_out, .sync_serial_clock_out, .sync_serial_clock_oe,
      .sync_serial_data_in, .sync_serial_clock_in, .uart_a_transmit, .uart_b_transmit,
      .uart_a_receive, .pwm_channel_a, .pwm_channel_b);

   gio_pad_model pads (.aclk, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down,
      .ext_drive, .ext_en, .pin_level(pin_in));

   // 25 MHz clock
   always #20 aclk = ~aclk;

   // hang guard, far above the hundred or so cycles the tests need
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test

   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // one write; bready raised early and held until bvalid is seen
   task automatic wr(logic [15:0] idx, logic [31:0] d, logic [3:0] s, output logic [1:0] r);
      awaddr <= {idx, 2'b00};
      wdata  <= d;
      wstrb  <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      // idle edge, so a following call never re-raises bready in this step
      @(posedge aclk);
   endtask : wr

   // one read; rdata and rresp taken at the edge where rvalid is seen
   task automatic rd(logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      // idle edge, so a following call never re-raises rready in this step
      @(posedge aclk);
   endtask : rd

   // every register reads zero, pins released, sda, rxd and serial inputs idle high
   task automatic t_reset();
      for (int i = 0; i < 6; i++) begin
         rd(IDX_DATA + 16'(i), rd_v, rsp);
         chk("reset value", rd_v & 32'h0000_00ff, 32'(REG_RST));
         chk("reset resp", 32'(rsp), 32'(RESP_OK));
      end
      chk("reset oe", 32'(pin_oe), 32'h0000_0000);
      chk("reset sda in", 32'(i2c_sda_in), 32'h0000_0001);
      chk("reset rxd in", 32'(uart_a_receive), 32'h0000_0001);
      chk("reset ser din", 32'(sync_serial_data_in), 32'h0000_0001);
      chk("reset ser cin", 32'(sync_serial_clock_in), 32'h0000_0001);
   endtask : t_reset

   // cmos outputs by word write, then data pattern on the pins
   task automatic t_output();
      wr(IDX_CFGLO, 32'h0000_ffff, 4'h3, rsp);
      rd(IDX_CFGLO, rd_v, rsp);
      chk("config word", rd_v, 32'h0000_ffff);
      wr(IDX_DATA, 32'h0000_00a5, 4'h1, rsp);
      wr(IDX_DATA, 32'h0000_005a, 4'h2, rsp); // lane 0 off leaves the byte alone
      repeat (2) @(posedge aclk);
      chk("pin_out", 32'(pin_out), 32'h0000_00a5);
      chk("pin_oe", 32'(pin_oe), 32'h0000_00ff);
      rd(IDX_DATA, rd_v, rsp);
      chk("data readback", rd_v, 32'h0000_00a5);
   endtask : t_output

   // low nibble to input, outside driver sets those pins
   task automatic t_input();
      ext_drive <= 8'h3c;
      ext_en    <= 8'h0f;
      wr(IDX_DIR, 32'h0000_000f, 4'h1, rsp);
      repeat (4) @(posedge aclk);
      chk("mixed oe", 32'(pin_oe), 32'h0000_00f0);
      rd(IDX_DATA, rd_v, rsp);
      chk("mixed read", rd_v, 32'h0000_00ac);
   endtask : t_input

   // all inputs: low nibble pulled down, high nibble pulled up
   task automatic t_pulls();
      ext_en <= 8'h00;
      wr(IDX_DIR, 32'h0000_00ff, 4'h1, rsp);
      wr(IDX_CFGLO, 32'h0000_f00f, 4'h3, rsp);
      repeat (4) @(posedge aclk);
      chk("pull down", 32'(pin_pull_down), 32'h0000_000f);
      chk("pull up", 32'(pin_pull_up), 32'h0000_00f0);
      rd(IDX_DATA, rd_v, rsp);
      chk("pulled read", rd_v, 32'h0000_00f0);
   endtask : t_pulls

   // addresses just outside the block answer with an error
   task automatic t_unmapped();
      rd(IDX_FSHI + 16'h0001, rd_v, rsp);
      chk("unmapped rresp", 32'(rsp), 32'(RESP_ERR));
      chk("unmapped rdata", rd_v, 32'h0000_0000);
      wr(IDX_DATA - 16'h0001, 32'h0000_00ff, 4'h1, rsp);
      chk("unmapped bresp", 32'(rsp), 32'(RESP_ERR));
   endtask : t_unmapped

   // pins 0..2 secondary (i2c, uart rx), pin3 pwm a, pins 4/5 serial inputs
   task automatic t_alt();
      wr(IDX_DIR, 32'h0000_0000, 4'h1, rsp);
      wr(IDX_CFGLO, 32'h0000_ffff, 4'h3, rsp);
      wr(IDX_FSLO, 32'h0000_3807, 4'h3, rsp);
      ext_drive  <= 8'h00;
      ext_en     <= 8'h37;
      pwm_channel_a <= 1'b1;
      repeat (4) @(posedge aclk);
      chk("pwm high", 32'(pin_out[3]), 32'h0000_0001);
      chk("sda in", 32'(i2c_sda_in), 32'h0000_0000);
      chk("scl in", 32'(i2c_scl_in), 32'h0000_0000);
      chk("rxd in", 32'(uart_a_receive), 32'h0000_0000);
      chk("serial data in", 32'(sync_serial_data_in), 32'h0000_0000);
      chk("serial clock in", 32'(sync_serial_clock_in), 32'h0000_0000);
      pwm_channel_a <= 1'b0;
      ext_en     <= 8'h00;
      i2c_sda_oe <= 1'b1;
      repeat (2) @(posedge aclk);
      chk("pwm low", 32'(pin_out[3]), 32'h0000_0000);
      chk("sda drive", 32'({pin_oe[0], pin_out[0]}), 32'h0000_0002);
   endtask : t_alt

   // main sequence
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_reset();
      t_output();
      t_input();
      t_pulls();
      t_unmapped();
      t_alt();
      end_of_test();
   end
endmodule : tb
